//--- logic/drc_consts.svh
// drc_consts.svh: constants for the dma bus retry control block
// assumes inclusion by bare name from logic/
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH

// configuration bit positions
`define DRC_BIT_SYNC_BUS      10
`define DRC_BIT_LATCH_SELECT  13
`define DRC_BIT_ASYNC_RETRY   15
// reset values
`define DRC_RST_FLAG          1'b0
`define DRC_RST_STATE         2'h0
`define DRC_RST_ALLOW         1'b1
`define DRC_RST_REATT         1'b0
`define DRC_RST_IDLE          1'b0

`endif

//--- logic/drc_pkg.sv
// drc_pkg.sv: types for the dma bus retry control block
// assumes drc_consts.svh sits beside it
package drc_pkg;
    // master retry sequencing states
    typedef enum logic [1:0] {
        DRC_RUN   = 2'h0,
        DRC_DRAIN = 2'h1,
        DRC_OFF   = 2'h2,
        DRC_RESUME = 2'h3
    } drc_state_t;
endpackage : drc_pkg

//--- logic/drc_sample_if.sv
// drc_sample_if.sv: carries sampled retry between sampler and control
// assumes both ends share clk
`timescale 1ns/1ps
interface drc_sample_if;
    logic retry_sampled;
    modport src (output retry_sampled);
    modport dst (input  retry_sampled);
endinterface : drc_sample_if

//--- logic/drc_retry_sampler.sv
// drc_retry_sampler.sv: picks rising or falling edge capture of retry
// assumes clk is the bus clock, rstn synchronous active low
`timescale 1ns/1ps
module drc_retry_sampler (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rstn,
    // retry pin and mode
    input  wire logic  bus_retry_input,
    input  wire logic  use_falling,
    // sampled result
    drc_sample_if.src  smp
);
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;

    // next values of both capture stages
    always_comb begin
        rise_d = bus_retry_input;
        fall_d = bus_retry_input;
    end

    // rising edge capture
    always_ff @(posedge clk) begin
        if (!rstn) rise_q <= 1'b0;
        else rise_q <= rise_d;
    end

    // falling edge capture, seen by rising logic half a cycle later
    always_ff @(negedge clk) begin
        if (!rstn) fall_q <= 1'b0;
        else fall_q <= fall_d;
    end

    assign smp.retry_sampled = use_falling ? fall_q : rise_q;
endmodule : drc_retry_sampler

//--- logic/drc_retry_ctrl.sv
// drc_retry_ctrl.sv: bus retry handling of a dma bus master
// assumes dma engine gives op boundaries, retry pin is bus-synchronous
// Function
// - falling-edge retry capture when async option on
// - async capture only in asynchronous bus mode without extended bus select
// - bit 13 selects latched or unlatched retry
// - unlatched: finish current operation, release bus
// - unlatched: reattempt once retry deasserts
// - latched: reattempt after deassert and flag cleared
`timescale 1ns/1ps
`include "drc_consts.svh"
module drc_retry_ctrl #(
    // width of the configuration word that carries the mode bits
    parameter int CFG_W = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // configuration
    input  wire logic [CFG_W-1:0] config_word,
    input  wire logic             extended_bus_select,
    // bus retry pin
    input  wire logic             bus_retry_input,
    // dma engine side
    input  wire logic             dma_request,
    input  wire logic             dma_op_done,
    // status flag clear from software
    input  wire logic             retry_flag_clear,
    // outputs
    output logic                  bus_grant_allow,
    output logic                  dma_reattempt,
    output logic                  retry_status_flag,
    output logic                  bus_idle
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks on the parameter set

    // every mode bit must sit inside the configuration word
    if (CFG_W <= `DRC_BIT_ASYNC_RETRY) begin : g_bad_width_async
        $error("config word too narrow for async retry bit");
    end
    if (CFG_W <= `DRC_BIT_LATCH_SELECT) begin : g_bad_width_latch
        $error("config word too narrow for latch select bit");
    end
    if (CFG_W <= `DRC_BIT_SYNC_BUS) begin : g_bad_width_sync
        $error("config word too narrow for bus mode bit");
    end
    // the three mode bits must be distinct positions
    if (`DRC_BIT_ASYNC_RETRY == `DRC_BIT_LATCH_SELECT ||
        `DRC_BIT_ASYNC_RETRY == `DRC_BIT_SYNC_BUS ||
        `DRC_BIT_LATCH_SELECT == `DRC_BIT_SYNC_BUS) begin : g_bad_bits
        $error("mode bits overlap in the config word");
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded mode bits
    logic                 async_opt;
    logic                 sync_bus;
    logic                 latch_sel;
    logic                 use_falling;
    // sampled retry and its qualified forms
    logic                 retry_now;
    logic                 retry_taken;
    logic                 resume_ok;
    // sequencing state
    drc_pkg::drc_state_t  state_q;
    drc_pkg::drc_state_t  state_d;
    // sticky status flag
    logic                 flag_q;
    logic                 flag_d;
    // registered outputs
    logic                 allow_q;
    logic                 allow_d;
    logic                 reatt_q;
    logic                 reatt_d;
    logic                 idle_q;
    logic                 idle_d;

    // carrier between sampler and sequencer
    drc_sample_if smp_if ();

    ////////////////////////////////////////////////////////////////////////
    // configuration decode
    assign async_opt = config_word[`DRC_BIT_ASYNC_RETRY];
    assign sync_bus  = config_word[`DRC_BIT_SYNC_BUS];
    assign latch_sel = config_word[`DRC_BIT_LATCH_SELECT];
    // falling capture only async option, async bus, no extended bus
    assign use_falling = async_opt && !sync_bus && !extended_bus_select;

    // edge choice lives in the sampler, sequencer sees one bit
    drc_retry_sampler u_sampler (
        .clk             (clk),
        .rstn            (rstn),
        .bus_retry_input (bus_retry_input),
        .use_falling     (use_falling),
        .smp             (smp_if.src)
    );
    assign retry_now = smp_if.retry_sampled;

    ////////////////////////////////////////////////////////////////////////
    // retry qualification

    // retry only counts while the engine owns the bus in run state
    assign retry_taken = retry_now && dma_request &&
                         (state_q == drc_pkg::DRC_RUN);
    // way back needs retry low and, when latched, a clear flag
    always_comb begin
        resume_ok = 1'b0;
        if (!retry_now) begin
            if (!latch_sel) begin
                resume_ok = 1'b1;
            end else begin
                resume_ok = !flag_q || retry_flag_clear;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky retry status flag

    // set wins over a clear in the same cycle, so no retry is lost
    always_comb begin
        flag_d = flag_q;
        if (retry_flag_clear) begin
            flag_d = 1'b0;
        end
        if (retry_taken) begin
            flag_d = 1'b1;
        end
    end

    // register the flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_q <= `DRC_RST_FLAG;
        end else begin
            flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // retry sequencing

    // next sequencing state
    always_comb begin
        state_d = state_q;
        case (state_q)
            drc_pkg::DRC_RUN: begin
                // op ending in the retry cycle skips the drain
                if (retry_taken) begin
                    if (dma_op_done) begin
                        state_d = drc_pkg::DRC_OFF;
                    end else begin
                        state_d = drc_pkg::DRC_DRAIN;
                    end
                end
            end
            drc_pkg::DRC_DRAIN: begin
                // let the current operation finish first
                if (dma_op_done) begin
                    state_d = drc_pkg::DRC_OFF;
                end
            end
            drc_pkg::DRC_OFF: begin
                // off the bus; latched mode also waits for software
                if (resume_ok) begin
                    state_d = drc_pkg::DRC_RESUME;
                end
            end
            drc_pkg::DRC_RESUME: begin
                // one cycle to flag the reattempt, then run again
                state_d = drc_pkg::DRC_RUN;
            end
            default: begin
                state_d = drc_pkg::DRC_RUN;
            end
        endcase
    end

    // register the state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= drc_pkg::drc_state_t'(`DRC_RST_STATE);
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    // allow and idle decoded from the next state so they track the state flops; reattempt from the current state
    always_comb begin
        allow_d = (state_d == drc_pkg::DRC_RUN) ||
                  (state_d == drc_pkg::DRC_DRAIN);
        idle_d  = (state_d == drc_pkg::DRC_OFF);
        reatt_d = (state_q == drc_pkg::DRC_RESUME);
    end

    // register the outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            allow_q <= `DRC_RST_ALLOW;
            reatt_q <= `DRC_RST_REATT;
            idle_q  <= `DRC_RST_IDLE;
        end else begin
            allow_q <= allow_d;
            reatt_q <= reatt_d;
            idle_q  <= idle_d;
        end
    end

    // outputs straight from flops
    assign bus_grant_allow   = allow_q;
    assign dma_reattempt     = reatt_q;
    assign retry_status_flag = flag_q;
    assign bus_idle          = idle_q;
endmodule : drc_retry_ctrl

//--- verification/drc_monitor.sv
// drc_monitor.sv: port assertions for drc_retry_ctrl
// assumes bind from testbench, one clock domain
`timescale 1ns/1ps
module drc_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // inputs
    input wire logic [15:0] config_word,
    input wire logic        extended_bus_select,
    input wire logic        bus_retry_input,
    input wire logic        retry_flag_clear,
    // outputs
    input wire logic        bus_grant_allow,
    input wire logic        dma_reattempt,
    input wire logic        retry_status_flag,
    input wire logic        bus_idle
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_drop_on_retry: assert property (
        $fell(bus_grant_allow) |-> $past(bus_retry_input))
        else $error("bus released without retry");
    a_rise_edge_only: assert property (
        $rose(retry_status_flag) && (config_word[10] ||
        extended_bus_select || !config_word[15]) |->
        $past(bus_retry_input) || $past(bus_retry_input, 2))
        else $error("retry seen between rising edges");
    a_unl_resume: assert property (
        !config_word[13] && bus_idle && $fell(bus_retry_input)
        |-> ##[1:4] dma_reattempt) else $error("no reattempt");
    a_reat_pulse: assert property (
        dma_reattempt |-> bus_grant_allow && !bus_idle
        ##1 !dma_reattempt) else $error("bad reattempt pulse");
    a_latch_wait: assert property (
        dma_reattempt && config_word[13] |-> !retry_status_flag)
        else $error("reattempt with flag set");
    a_flag_sticky: assert property (
        retry_status_flag && !retry_flag_clear |=> retry_status_flag)
        else $error("flag lost");
    a_idle_hold: assert property (
        bus_idle && $past(bus_retry_input) && (config_word[10] ||
        extended_bus_select || !config_word[15]) |->
        ##2 !dma_reattempt) else $error("reattempt under retry");
endmodule : drc_monitor

//--- verification/drc_bus_model.sv
// drc_bus_model.sv: bus logic driving the retry pin
// assumes bench sets want and latched
`timescale 1ns/1ps
module drc_bus_model (
    // clock and control
    input  wire logic clk,
    input  wire logic want,
    input  wire logic latched,
    // master side
    input  wire logic bus_idle,
    output logic      bus_retry_input
);
    logic hold_q = 1'b0;
    logic glt    = 1'b0;
    // keep retry up until the master is idle, in unlatched mode only
    always @(posedge clk) begin
        hold_q <= want | (hold_q & ~latched & ~bus_idle);
    end
    assign bus_retry_input = hold_q | glt;
    // pulse seen only by the falling edge
    task glitch;
        @(posedge clk);
        #2 glt = 1'b1;
        @(negedge clk);
        #2 glt = 1'b0;
    endtask : glitch
endmodule : drc_bus_model

//--- verification/testbench.sv
// testbench.sv: directed tests of drc_retry_ctrl
// assumes monitor and bus model compiled first
`timescale 1ns/1ps
module testbench;
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] cw   = 16'h0;
    logic        ext  = 1'b0;
    logic        done = 1'b0;
    logic        clr  = 1'b0;
    logic        want = 1'b0;
    logic        req  = 1'b1;
    logic        pin, allow, reat, flag, idle;
    logic [15:0] cws [4] = '{16'h2000, 16'ha000, 16'ha400, 16'ha000};
    int          failures   = 0;
    int          num_checks = 0;
    int          i;
    always #12.5 clk = ~clk;
    drc_bus_model bm (.clk, .want, .latched(cw[13]),
        .bus_idle(idle), .bus_retry_input(pin));
    drc_retry_ctrl DUT (.clk, .rstn, .config_word(cw),
        .extended_bus_select(ext), .bus_retry_input(pin),
        .dma_request(req), .dma_op_done(done),
        .retry_flag_clear(clr), .bus_grant_allow(allow),
        .dma_reattempt(reat), .retry_status_flag(flag),
        .bus_idle(idle));
    task step(input int n);
        repeat (n) begin
            @(posedge clk);
            #2;
        end
    endtask : step
    task cmp(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task rst;
        rstn = 1'b0;
        step(4);
        rstn = 1'b1;
    endtask : rst
    // retry during an op, op ends, wait for release
    task take;
        want = 1'b1;
        step(4);
        cmp(allow, 1'b1);
        done = 1'b1;
        step(1);
        done = 1'b0;
        for (i = 0; i < 9 && idle !== 1'b1; i++) step(1);
        cmp(idle, 1'b1);
        cmp(allow, 1'b0);
        want = 1'b0;
    endtask : take
    task stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial begin
        begin : tests
            rst();
            take();
            if (idle !== 1'b1) disable tests;
            for (i = 0; i < 9 && reat !== 1'b1; i++) step(1);
            cmp(reat, 1'b1);
            if (reat !== 1'b1) disable tests;
            $display("test unlatched ended");
            cw = 16'h2000;
            rst();
            take();
            if (idle !== 1'b1) disable tests;
            step(6);
            cmp(idle, 1'b1);
            clr = 1'b1;
            step(1);
            clr = 1'b0;
            for (i = 0; i < 9 && reat !== 1'b1; i++) step(1);
            cmp(reat, 1'b1);
            if (reat !== 1'b1) disable tests;
            $display("test latched ended");
            for (int m = 0; m < 4; m++) begin
                cw = cws[m];
                ext = m[1] & m[0];
                rst();
                bm.glitch();
                step(3);
                cmp(flag, m == 1);
            end
            $display("test edges ended");
            // retry while the engine holds no request is ignored
            cw = 16'h2000;
            ext = 1'b0;
            req = 1'b0;
            rst();
            want = 1'b1;
            step(4);
            cmp(flag, 1'b0);
            cmp(allow, 1'b1);
            want = 1'b0;
            $display("test refused ended");
        end
        stop_test();
    end
endmodule : testbench
bind drc_retry_ctrl drc_monitor mon (.clk, .rstn, .config_word,
    .extended_bus_select, .bus_retry_input, .retry_flag_clear,
    .bus_grant_allow, .dma_reattempt, .retry_status_flag, .bus_idle);
